// ---- tlrf_pkg.sv ----
// Shared constants for the tile local RAM/FIFO: register map, field positions,
// reset values, modes and widths.
// Assumes a 10 MHz system clock and a 32-bit register port.
package tlrf_pkg;

	localparam int unsigned CLK_HZ      = 10_000_000;
	localparam int unsigned REG_AW      = 8;
	localparam int unsigned REG_DW      = 32;
	localparam int unsigned WORD_W      = 36;
	localparam int unsigned MEM_WORDS   = 64;
	localparam int unsigned ADDR_W      = 6;
	localparam int unsigned PTR_W       = 7;
	localparam int unsigned PORT_W      = 144;
	localparam int unsigned CE_W        = 12;
	localparam int unsigned EXP_W       = 8;

	// Register byte offsets
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_WR_PTR   = 8'h04;
	localparam logic [7:0] REG_RD_PTR   = 8'h08;
	localparam logic [7:0] REG_THRESH   = 8'h0c;
	localparam logic [7:0] REG_STATUS   = 8'h10;

	// Control register fields
	localparam int unsigned CTRL_IN_MODE    = 0;
	localparam int unsigned CTRL_OUT_MODE   = 2;
	localparam int unsigned CTRL_WR_WIDTH   = 4;
	localparam int unsigned CTRL_RD_WIDTH   = 6;
	localparam int unsigned CTRL_FIFO_EN    = 8;
	localparam int unsigned CTRL_IGNORE     = 9;
	localparam int unsigned CTRL_SYNC       = 10;
	localparam int unsigned CTRL_REG_DOUT   = 11;
	localparam int unsigned CTRL_RST_STYLE  = 12;
	localparam int unsigned CTRL_CLEAR_EN   = 13;
	localparam int unsigned CTRL_WR_FALL    = 14;
	localparam int unsigned CTRL_RD_FALL    = 15;

	// Pointer, threshold and status register fields
	localparam int unsigned FLD_LO          = 0;
	localparam int unsigned FLD_HI          = 8;
	localparam int unsigned STAT_WR_PTR     = 8;
	localparam int unsigned STAT_RD_PTR     = 16;

	// Reset values
	localparam logic [PTR_W-1:0] PTR_START_RST  = 7'h00;
	localparam logic [PTR_W-1:0] PTR_MAX_RST    = 7'h7f;
	localparam logic [PTR_W-1:0] AFULL_RST      = 7'h3f;
	localparam logic [PTR_W-1:0] AEMPTY_RST     = 7'h00;

	// Control source modes
	localparam logic [1:0] MODE_BRAM    = 2'h0;
	localparam logic [1:0] MODE_TILE    = 2'h1;
	localparam logic [1:0] MODE_PTRRST  = 2'h2;
	localparam logic [1:0] MODE_OFF     = 2'h3;

	// Width encodings
	localparam logic [1:0] WID_72       = 2'h0;
	localparam logic [1:0] WID_36       = 2'h1;
	localparam logic [1:0] WID_144      = 2'h2;

	// Tile input bit positions
	localparam int unsigned CE_WREN     = 7;
	localparam int unsigned CE_RDEN     = 6;
	localparam int unsigned CE_WRRST    = 9;
	localparam int unsigned CE_RDRST    = 8;

endpackage

// ---- tlrf_edge_sync.sv ----
// Three-stage synchroniser for an external clock pin with edge pulses.
// Assumes the pin toggles well below half the system clock rate.
module tlrf_edge_sync (
	input  wire logic clk_i,
	input  wire logic arst_n_i,
	input  wire logic pin_i,
	output logic      rise_o,
	output logic      fall_o
);
	import tlrf_pkg::*;

	typedef struct packed {
		logic [2:0] sync;
		logic       level;
		logic       rise;
		logic       fall;
	} tlrf_es_state_t;

	tlrf_es_state_t s_r;
	tlrf_es_state_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.sync = {s_r.sync[1:0], pin_i};
		s_nxt.rise = 1'b0;
		s_nxt.fall = 1'b0;
		// Stage one feeds only stage two; stages two and three decide
		if (s_r.sync[1] == s_r.sync[2] && s_r.sync[2] != s_r.level) begin
			s_nxt.level = s_r.sync[2];
			s_nxt.rise  = s_r.sync[2];
			s_nxt.fall  = ~s_r.sync[2];
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rise_o = s_r.rise;
	assign fall_o = s_r.fall;
endmodule

// ---- tlrf_core.sv ----
// Tile local RAM/FIFO: 2 kbit store, RAM or FIFO, with register port.
// Assumes tile and block-memory controls are on clk_i; the write and read
// clock pins are external and sampled as edge enables.
//
// Operation
// - 2 kbit as 64x36, 32x72, 16x144
// - Mode 0 controls from block memory
// - Mode 1 RAM or FIFO, tile inputs
// - Write address and enable per mode
// - Read address and enable per mode
// - Output reset inactive mode 0, else rstn
// - Mode 2 write pointer reset to start
// - Mode 2 read pointer reset to start
// - Programmable pointer start and maximum values
// - Ignore flags: full write overwrites, errors
// - Ignore flags: empty read repeats, errors
// - Rise or fall edge per side
// - Sync mode shares one clock
// - Output register or unregistered read data
// - Output reset synchronous or asynchronous
// - FIFO enable selects FIFO or RAM
// - Clear enable zeroes memory on reset
// - Output register reset by rstn except in mode 0
// - Refuse full writes, empty reads, flag
// - 7-bit pointer settings, default 0/7f
// - Empty, full, almost flags with thresholds
//
// Decided for this implementation: the strobed register port and the register addresses.
module tlrf_core (
	input  wire logic                           clk_i,
	input  wire logic                           arst_n_i,
	input  wire logic [tlrf_pkg::REG_AW-1:0]    reg_addr_i,
	input  wire logic [tlrf_pkg::REG_DW-1:0]    reg_wdata_i,
	input  wire logic                           reg_wr_i,
	input  wire logic                           reg_rd_i,
	output logic      [tlrf_pkg::REG_DW-1:0]    reg_rdata_o,
	input  wire logic                           wr_clk_i,
	input  wire logic                           rd_clk_i,
	input  wire logic [tlrf_pkg::PORT_W-1:0]    bm_din_i,
	input  wire logic [tlrf_pkg::ADDR_W-1:0]    bm_wraddr_i,
	input  wire logic [tlrf_pkg::ADDR_W-1:0]    bm_rdaddr_i,
	input  wire logic                           bm_wren_i,
	input  wire logic                           bm_rden_i,
	input  wire logic [tlrf_pkg::PORT_W-1:0]    tile_din_i,
	input  wire logic [tlrf_pkg::EXP_W-1:0]     tile_expb_i,
	input  wire logic [tlrf_pkg::CE_W-1:0]      tile_ce_i,
	input  wire logic                           tile_rst_n_i,
	output logic      [tlrf_pkg::PORT_W-1:0]    rd_data_o,
	output logic                                empty_o,
	output logic                                full_o,
	output logic                                almost_empty_o,
	output logic                                almost_full_o,
	output logic                                write_error_o,
	output logic                                read_error_o
);
	import tlrf_pkg::*;

	typedef struct packed {
		logic [1:0]                         in_mode;
		logic [1:0]                         out_mode;
		logic [1:0]                         wr_width;
		logic [1:0]                         rd_width;
		logic                               fifo_en;
		logic                               ignore_flags;
		logic                               sync_mode;
		logic                               reg_dout;
		logic                               output_reset_style;
		logic                               clear_en;
		logic                               wr_fall;
		logic                               rd_fall;
		logic [PTR_W-1:0]                   wr_start;
		logic [PTR_W-1:0]                   wr_max;
		logic [PTR_W-1:0]                   rd_start;
		logic [PTR_W-1:0]                   rd_max;
		logic [PTR_W-1:0]                   afull_thr;
		logic [PTR_W-1:0]                   aempty_thr;
		logic [PTR_W-1:0]                   wr_ptr;
		logic [PTR_W-1:0]                   rd_ptr;
		logic [MEM_WORDS-1:0][WORD_W-1:0]   mem;
		logic [PORT_W-1:0]                  out_reg;
		logic [PORT_W-1:0]                  dout;
		logic [REG_DW-1:0]                  rdata;
		logic                               empty;
		logic                               full;
		logic                               aempty;
		logic                               afull;
		logic                               werr;
		logic                               rerr;
	} tlrf_state_t;

	tlrf_state_t s_r, s_nxt;

	logic        w_rise, w_fall, r_rise, r_fall;

	tlrf_edge_sync u_wr_edge (
		.clk_i    (clk_i),
		.arst_n_i (arst_n_i),
		.pin_i    (wr_clk_i),
		.rise_o   (w_rise),
		.fall_o   (w_fall)
	);

	tlrf_edge_sync u_rd_edge (
		.clk_i    (clk_i),
		.arst_n_i (arst_n_i),
		.pin_i    (rd_clk_i),
		.rise_o   (r_rise),
		.fall_o   (r_fall)
	);

	function automatic logic [2:0] words_of(input logic [1:0] wid);
		case (wid)
			WID_36:  words_of = 3'h1;
			WID_144: words_of = 3'h4;
			default: words_of = 3'h2;
		endcase
	endfunction

	// First 36-bit word of an address, out-of-depth bits dropped
	function automatic logic [ADDR_W-1:0] base_of(input logic [ADDR_W-1:0] a, input logic [1:0] wid);
		case (wid)
			WID_36:  base_of = a;
			WID_144: base_of = {a[3:0], 2'h0};
			default: base_of = {a[4:0], 1'h0};
		endcase
	endfunction

	function automatic logic [PORT_W-1:0] read_word(input logic [MEM_WORDS-1:0][WORD_W-1:0] m,
			input logic [ADDR_W-1:0] a, input logic [1:0] wid);
		logic [ADDR_W-1:0] b;
		b = base_of(a, wid);
		read_word = '0;
		for (int j = 0; j < 4; j++) begin
			if (3'(j) < words_of(wid)) begin
				read_word[j*WORD_W +: WORD_W] = m[b + ADDR_W'(j)];
			end
		end
	endfunction

	function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p,
			input logic [PTR_W-1:0] start, input logic [PTR_W-1:0] max);
		ptr_inc = (p == max) ? start : p + 7'h01;
	endfunction

	logic                   wr_edge, rd_edge, wr_en, rd_en, regrst_n, wr_rst, rd_rst, fifo_act, do_write;
	logic [ADDR_W-1:0]      wr_addr, rd_addr, mem_wa, wb;
	logic [PORT_W-1:0]      wr_data;
	logic [PTR_W:0]         wr_len, occ;

	always_comb begin
		s_nxt = s_r;
		wr_edge = s_r.wr_fall ? w_fall : w_rise;
		// shared clock takes read edges from write pin
		if (s_r.sync_mode) begin
			rd_edge = s_r.rd_fall ? w_fall : w_rise;
		end else begin
			rd_edge = s_r.rd_fall ? r_fall : r_rise;
		end
		wr_edge = wr_edge && (s_r.in_mode != MODE_OFF);
		rd_edge = rd_edge && (s_r.out_mode != MODE_OFF);

		case (s_r.in_mode)
			MODE_BRAM: begin
				wr_en   = bm_wren_i;
				wr_addr = bm_wraddr_i;
				wr_data = bm_din_i;
			end
			MODE_TILE: begin
				wr_en   = tile_ce_i[CE_WREN];
				wr_addr = tile_expb_i[7:2];
				wr_data = tile_din_i;
			end
			default: begin
				wr_en   = tile_ce_i[CE_WREN];
				wr_addr = '0;
				wr_data = tile_din_i;
			end
		endcase
		case (s_r.out_mode)
			MODE_BRAM: begin
				rd_en    = bm_rden_i;
				rd_addr  = bm_rdaddr_i;
				regrst_n = 1'b1;
			end
			MODE_TILE: begin
				rd_en    = tile_ce_i[CE_RDEN];
				rd_addr  = {tile_expb_i[1:0], tile_ce_i[11:8]};
				regrst_n = tile_rst_n_i;
			end
			default: begin
				rd_en    = tile_ce_i[CE_RDEN];
				rd_addr  = '0;
				regrst_n = tile_rst_n_i;
			end
		endcase
		// pointer resets only in mode 2
		wr_rst = (s_r.in_mode == MODE_PTRRST) && tile_ce_i[CE_WRRST];
		rd_rst = (s_r.out_mode == MODE_PTRRST) && tile_ce_i[CE_RDRST];
		// FIFO only outside block-memory mode; mode 2 assumes FIFO on
		fifo_act = s_r.fifo_en && (s_r.in_mode != MODE_BRAM);
		// Write side
		do_write = 1'b0;
		mem_wa   = wr_addr;
		if (wr_edge) begin
			if (fifo_act) begin
				mem_wa = s_r.wr_ptr[ADDR_W-1:0];
				s_nxt.werr = wr_en && s_r.full;
				// reset beats a write at the same edge
				if (wr_rst) begin
					s_nxt.wr_ptr = s_r.wr_start;
				end else if (wr_en && !s_r.full) begin
					do_write     = 1'b1;
					s_nxt.wr_ptr = ptr_inc(s_r.wr_ptr, s_r.wr_start, s_r.wr_max);
				end else if (wr_en && s_r.ignore_flags) begin
					do_write = 1'b1;
				end
			end else begin
				do_write   = wr_en;
				s_nxt.werr = 1'b0;
			end
		end
		wb = base_of(mem_wa, s_r.wr_width);
		if (do_write) begin
			for (int j = 0; j < 4; j++) begin
				if (3'(j) < words_of(s_r.wr_width)) begin
					s_nxt.mem[wb + ADDR_W'(j)] = wr_data[j*WORD_W +: WORD_W];
				end
			end
		end

		// Read side
		if (rd_edge) begin
			if (fifo_act) begin
				s_nxt.rerr = rd_en && s_r.empty;
				// reset beats a read at the same edge
				if (rd_rst) begin
					s_nxt.rd_ptr = s_r.rd_start;
				end else if (rd_en && !s_r.empty) begin
					s_nxt.out_reg = read_word(s_r.mem, s_r.rd_ptr[ADDR_W-1:0], s_r.rd_width);
					s_nxt.rd_ptr  = ptr_inc(s_r.rd_ptr, s_r.rd_start, s_r.rd_max);
				end else if (rd_en && s_r.ignore_flags) begin
					s_nxt.out_reg = read_word(s_r.mem, s_r.rd_ptr[ADDR_W-1:0], s_r.rd_width);
				end
			end else begin
				s_nxt.rerr = 1'b0;
				if (rd_en) begin
					s_nxt.out_reg = read_word(s_r.mem, rd_addr, s_r.rd_width);
				end
			end
		end

		// output register reset, sync waits for a read edge
		if (!regrst_n && (s_r.output_reset_style || rd_edge)) begin
			s_nxt.out_reg = '0;
		end
		if (!regrst_n && s_r.clear_en) begin
			s_nxt.mem = '0;
		end

		if (s_r.reg_dout) begin
			s_nxt.dout = s_nxt.out_reg;
		end else begin
			s_nxt.dout = read_word(s_r.mem, fifo_act ? s_r.rd_ptr[ADDR_W-1:0] : rd_addr, s_r.rd_width);
		end

		// both pointers live on clk_i, so flags see a coherent pair
		wr_len = {1'b0, s_r.wr_max} - {1'b0, s_r.wr_start} + 8'h01;
		// Next pointers, so almost flags move with empty and full
		if (s_nxt.wr_ptr >= s_nxt.rd_ptr) begin
			occ = {1'b0, s_nxt.wr_ptr} - {1'b0, s_nxt.rd_ptr};
		end else begin
			occ = {1'b0, s_nxt.wr_ptr} + wr_len - {1'b0, s_nxt.rd_ptr};
		end
		s_nxt.empty  = fifo_act && (s_nxt.rd_ptr == s_nxt.wr_ptr);
		s_nxt.full   = fifo_act && (ptr_inc(s_nxt.wr_ptr, s_r.wr_start, s_r.wr_max) == s_nxt.rd_ptr);
		s_nxt.aempty = fifo_act && (occ <= {1'b0, s_r.aempty_thr});
		s_nxt.afull  = fifo_act && (occ >= {1'b0, s_r.afull_thr});

		// Register port writes
		if (reg_wr_i) begin
			case (reg_addr_i)
				REG_CTRL: begin
					s_nxt.in_mode            = reg_wdata_i[CTRL_IN_MODE +: 2];
					s_nxt.out_mode           = reg_wdata_i[CTRL_OUT_MODE +: 2];
					s_nxt.wr_width           = reg_wdata_i[CTRL_WR_WIDTH +: 2];
					s_nxt.rd_width           = reg_wdata_i[CTRL_RD_WIDTH +: 2];
					s_nxt.fifo_en            = reg_wdata_i[CTRL_FIFO_EN];
					s_nxt.ignore_flags       = reg_wdata_i[CTRL_IGNORE];
					s_nxt.sync_mode          = reg_wdata_i[CTRL_SYNC];
					s_nxt.reg_dout           = reg_wdata_i[CTRL_REG_DOUT];
					s_nxt.output_reset_style = reg_wdata_i[CTRL_RST_STYLE];
					s_nxt.clear_en           = reg_wdata_i[CTRL_CLEAR_EN];
					s_nxt.wr_fall            = reg_wdata_i[CTRL_WR_FALL];
					s_nxt.rd_fall            = reg_wdata_i[CTRL_RD_FALL];
				end
				REG_WR_PTR: begin
					s_nxt.wr_start = reg_wdata_i[FLD_LO +: PTR_W];
					s_nxt.wr_max   = reg_wdata_i[FLD_HI +: PTR_W];
				end
				REG_RD_PTR: begin
					s_nxt.rd_start = reg_wdata_i[FLD_LO +: PTR_W];
					s_nxt.rd_max   = reg_wdata_i[FLD_HI +: PTR_W];
				end
				REG_THRESH: begin
					s_nxt.afull_thr  = reg_wdata_i[FLD_LO +: PTR_W];
					s_nxt.aempty_thr = reg_wdata_i[FLD_HI +: PTR_W];
				end
				default: begin
				end
			endcase
		end

		// Register port reads, unmapped reads return zero
		s_nxt.rdata = '0;
		if (reg_rd_i) begin
			case (reg_addr_i)
				REG_CTRL: begin
					s_nxt.rdata = {16'h0, s_r.rd_fall, s_r.wr_fall, s_r.clear_en, s_r.output_reset_style,
						s_r.reg_dout, s_r.sync_mode, s_r.ignore_flags, s_r.fifo_en,
						s_r.rd_width, s_r.wr_width, s_r.out_mode, s_r.in_mode};
				end
				REG_WR_PTR: s_nxt.rdata = {17'h0, s_r.wr_max, 1'b0, s_r.wr_start};
				REG_RD_PTR: s_nxt.rdata = {17'h0, s_r.rd_max, 1'b0, s_r.rd_start};
				REG_THRESH: s_nxt.rdata = {17'h0, s_r.aempty_thr, 1'b0, s_r.afull_thr};
				REG_STATUS: begin
					s_nxt.rdata = {9'h0, s_r.rd_ptr, 1'b0, s_r.wr_ptr, 2'h0,
						s_r.rerr, s_r.werr, s_r.afull, s_r.aempty, s_r.full, s_r.empty};
				end
				default: s_nxt.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s_r            <= '0;
			s_r.wr_start   <= PTR_START_RST;
			s_r.rd_start   <= PTR_START_RST;
			s_r.wr_max     <= PTR_MAX_RST;
			s_r.rd_max     <= PTR_MAX_RST;
			s_r.afull_thr  <= AFULL_RST;
			s_r.aempty_thr <= AEMPTY_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign reg_rdata_o    = s_r.rdata;
	assign rd_data_o      = s_r.dout;
	assign empty_o        = s_r.empty;
	assign full_o         = s_r.full;
	assign almost_empty_o = s_r.aempty;
	assign almost_full_o  = s_r.afull;
	assign write_error_o  = s_r.werr;
	assign read_error_o   = s_r.rerr;
endmodule

// ---- tlrf_tile_model.sv ----
// Stand-in for the tile datapath and the co-sited block memory.
// Assumes clk_i samples the pin clocks; pins rest low between frames.
module tlrf_tile_model (
	input  wire logic                   clk_i,
	output logic                        wr_clk_o,
	output logic                        rd_clk_o,
	output logic [tlrf_pkg::PORT_W-1:0] din_o,
	output logic [tlrf_pkg::ADDR_W-1:0] bm_addr_o,
	output logic                        bm_wren_o,
	output logic                        bm_rden_o,
	output logic [tlrf_pkg::EXP_W-1:0]  expb_o,
	output logic [tlrf_pkg::CE_W-1:0]   ce_o,
	output logic                        rst_n_o
);
	import tlrf_pkg::*;
	initial begin
		{wr_clk_o, rd_clk_o, bm_wren_o, bm_rden_o} = '0;
		din_o = '0;
		bm_addr_o = '0;
		expb_o = '0;
		ce_o = '0;
		rst_n_o = 1'b1;
	end
	task automatic access(input bit rd, input logic [CE_W-1:0] ce, input logic [EXP_W-1:0] eb,
			input logic [PORT_W-1:0] d, input bit bm, input logic [ADDR_W-1:0] ba);
		@(posedge clk_i);
		ce_o <= ce;
		expb_o <= eb;
		din_o <= d;
		bm_addr_o <= ba;
		bm_wren_o <= bm & !rd;
		bm_rden_o <= bm & rd;
		// Controls settle well before the pin edge
		repeat (5) @(posedge clk_i);
		if (rd)
			rd_clk_o <= 1'b1;
		else
			wr_clk_o <= 1'b1;
		repeat (4) @(posedge clk_i);
		rd_clk_o <= 1'b0;
		wr_clk_o <= 1'b0;
		// Falling-edge enables act five clocks after the drop; keep a margin
		repeat (6) @(posedge clk_i);
		// Released data shows the inverse, so stale values never match
		din_o <= ~d;
		ce_o <= ce & ~12'h0c0;
		bm_wren_o <= 1'b0;
		bm_rden_o <= 1'b0;
		@(negedge clk_i);
	endtask
	task automatic hold_reset(input int n);
		@(posedge clk_i);
		rst_n_o <= 1'b0;
		repeat (n) @(posedge clk_i);
		rst_n_o <= 1'b1;
		@(negedge clk_i);
	endtask
endmodule

// ---- tlrf_monitor.sv ----
// Port checker for the tile local RAM/FIFO.
// Assumes pin clocks and tile controls are slow levels sampled on clk_i.
module tlrf_monitor (
	input wire logic                        clk_i,
	input wire logic                        arst_n_i,
	input wire logic [tlrf_pkg::REG_AW-1:0] reg_addr_i,
	input wire logic                        reg_wr_i,
	input wire logic                        reg_rd_i,
	input wire logic [tlrf_pkg::REG_DW-1:0] reg_rdata_o,
	input wire logic                        wr_clk_i,
	input wire logic                        rd_clk_i,
	input wire logic [tlrf_pkg::ADDR_W-1:0] bm_rdaddr_i,
	input wire logic [tlrf_pkg::EXP_W-1:0]  tile_expb_i,
	input wire logic [tlrf_pkg::CE_W-1:0]   tile_ce_i,
	input wire logic                        tile_rst_n_i,
	input wire logic [tlrf_pkg::PORT_W-1:0] rd_data_o,
	input wire logic                        empty_o,
	input wire logic                        full_o,
	input wire logic                        almost_empty_o,
	input wire logic                        almost_full_o,
	input wire logic                        write_error_o,
	input wire logic                        read_error_o
);
	import tlrf_pkg::*;
	logic [3:0] q_pin, q_all;
	logic [5:0] flags;
	assign flags = {read_error_o, write_error_o, almost_full_o, almost_empty_o, full_o, empty_o};
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!arst_n_i);
	// Quiet counters: flags and read data may not move without a pin edge, a control or address change, a tile reset or a config change
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			q_pin <= '0;
			q_all <= '0;
		end else begin
			q_pin <= (reg_wr_i || !tile_rst_n_i || $changed({wr_clk_i, rd_clk_i}))
				? '0 : q_pin + 4'(q_pin != 4'hf);
			q_all <= (reg_wr_i || !tile_rst_n_i || $changed({wr_clk_i, rd_clk_i, tile_ce_i, tile_expb_i, bm_rdaddr_i}))
				? '0 : q_all + 4'(q_all != 4'hf);
		end
	end
	a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == '0)
		else $error("read data not zero outside a read");
	a_status_copy: assert property (reg_rd_i && reg_addr_i == REG_STATUS |=> reg_rdata_o[5:0] == $past(flags))
		else $error("status bits differ from flag outputs");
	a_flags_quiet: assert property (q_all > 4'd8 |-> $stable(flags))
		else $error("flags moved without an access");
	a_data_quiet: assert property (q_all > 4'd8 |-> $stable(rd_data_o))
		else $error("read data moved without an access");
	a_werr_cause: assert property ($rose(write_error_o) |-> $past(full_o))
		else $error("write error without full");
	a_rerr_cause: assert property ($rose(read_error_o) |-> $past(empty_o))
		else $error("read error without empty");
	a_full_release: assert property ($fell(full_o) |-> q_pin < 4'd10)
		else $error("full dropped without an access");
	a_empty_release: assert property (empty_o ##1 !empty_o |-> q_pin < 4'd10)
		else $error("empty dropped without an access");
	c_werr: cover property ($rose(write_error_o));
	c_rerr: cover property ($rose(read_error_o));
	c_full: cover property ($rose(full_o));
endmodule

bind tlrf_core tlrf_monitor u_mon (
	.clk_i, .arst_n_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .wr_clk_i, .rd_clk_i,
	.bm_rdaddr_i, .tile_expb_i, .tile_ce_i, .tile_rst_n_i, .rd_data_o, .empty_o, .full_o,
	.almost_empty_o, .almost_full_o, .write_error_o, .read_error_o
);

// ---- tlrf_tb.sv ----
// Self-checking bench for the tile local RAM/FIFO with a reference model.
// Assumes the tile stand-in and the port checker are compiled first.
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import tlrf_pkg::*;
	logic              clk_i, arst_n_i, reg_wr_i, reg_rd_i;
	logic [REG_AW-1:0] reg_addr_i;
	logic [REG_DW-1:0] reg_wdata_i, reg_rdata_o, s;
	logic [PORT_W-1:0] din, rd_data_o, d;
	logic [ADDR_W-1:0] bm_addr;
	logic [EXP_W-1:0]  expb;
	logic [CE_W-1:0]   ce;
	logic              wr_clk, rd_clk, bm_wren, bm_rden, t_rst_n;
	logic              empty_o, full_o, aempty_o, afull_o, werr_o, rerr_o;
	logic [35:0]       mem [64];
	logic [31:0]       rng = 32'h20;
	logic [7:0]        ra [5] = '{REG_CTRL, REG_WR_PTR, REG_RD_PTR, REG_THRESH, 8'h20};
	logic [31:0]       rv [5] = '{32'h0, 32'h7f00, 32'h7f00, 32'h3f, 32'h0};
	int                err_count, samples_checked, wp, rp, wst, wmx, ign, werr, rerr;

	tlrf_core uut (
		.clk_i, .arst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
		.wr_clk_i(wr_clk), .rd_clk_i(rd_clk), .bm_din_i(din), .bm_wraddr_i(bm_addr), .bm_rdaddr_i(bm_addr),
		.bm_wren_i(bm_wren), .bm_rden_i(bm_rden), .tile_din_i(din), .tile_expb_i(expb), .tile_ce_i(ce),
		.tile_rst_n_i(t_rst_n), .rd_data_o, .empty_o, .full_o, .almost_empty_o(aempty_o),
		.almost_full_o(afull_o), .write_error_o(werr_o), .read_error_o(rerr_o));
	tlrf_tile_model tile (
		.clk_i, .wr_clk_o(wr_clk), .rd_clk_o(rd_clk), .din_o(din), .bm_addr_o(bm_addr),
		.bm_wren_o(bm_wren), .bm_rden_o(bm_rden), .expb_o(expb), .ce_o(ce), .rst_n_o(t_rst_n));

	function automatic logic [31:0] nxt(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function automatic logic [31:0] stat();
		int len, occ;
		len = wmx - wst + 1;
		occ = (wp - rp + len) % len;
		return {9'h0, 7'(rp), 1'b0, 7'(wp), 2'b0, 1'(rerr), 1'(werr), occ >= 2, occ <= 1, occ == len - 1, occ == 0};
	endfunction
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= v;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		@(negedge clk_i);
		v = reg_rdata_o;
	endtask
	task automatic op(input bit r, input logic [CE_W-1:0] xc);
		logic [35:0] ex;
		int full, empty;
		rng = nxt(rng);
		d = PORT_W'({5{rng}});
		full = ((wp == wmx) ? wst : wp + 1) == rp;
		empty = wp == rp;
		ex = mem[rp];
		if (xc[CE_WRRST])
			wp = wst;
		else if (xc[CE_RDRST])
			rp = wst;
		else if (!r) begin
			werr = full;
			if (!full || ign)
				mem[wp] = d[35:0];
			if (!full)
				wp = (wp == wmx) ? wst : wp + 1;
		end else begin
			rerr = empty;
			if (!empty)
				rp = (rp == wmx) ? wst : rp + 1;
		end
		tile.access(r, (r ? 12'h040 : 12'h080) | xc, 8'h00, d, 1'b0, '0); // write or read access, with any pointer resets
		if (r && xc == '0 && (!empty || ign))
			chk(64'(rd_data_o[35:0]), 64'(ex)); // read data
		rd(REG_STATUS, s);
		chk(64'(s), 64'(stat())); // status
	endtask
	task automatic run(input string p, input int ig);
		ign = ig;
		for (int i = 0; i < p.len(); i++)
			op(p[i] == "R", '0);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		err_count++;
		$display("MISMATCH t=%0t run did not finish", $time);
		give_verdict();
	end
	initial begin
		arst_n_i = 1'b0;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		reg_addr_i = '0;
		reg_wdata_i = '0;
		repeat (8) @(posedge clk_i);
		arst_n_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		foreach (ra[i]) begin
			rd(ra[i], s);
			chk(64'(s), 64'(rv[i])); // reset values
		end
		wst = 0;
		wmx = 3;
		wr(REG_WR_PTR, 32'h0300); // short range
		wr(REG_RD_PTR, 32'h0300); // short range
		wr(REG_THRESH, 32'h0102); // thresholds
		// Mode 1 FIFO, 36-bit words, output register
		wr(REG_CTRL, 32'h0955); // same modes
		run("WWWWRRRRWWR", 0); // refusals, wrap
		wr(REG_CTRL, 32'h0b55);
		run("WWWRRRRRWR", 1); // overwrite, re-read
		// Mode 2 only with FIFO operation
		wr(REG_CTRL, 32'h095a); // mode 2
		run("WWRR", 0);
		op(1'b0, 12'h200); // write pointer reset
		op(1'b1, 12'h100); // read pointer reset
		run("WR", 0);
		// Mode 1 RAM, async output reset, memory clear
		wr(REG_CTRL, 32'h3855);
		rng = nxt(rng);
		d = PORT_W'({5{rng}});
		tile.access(1'b0, 12'h080, 8'h14, d, 1'b0, '0); // write address
		tile.access(1'b1, 12'h540, 8'h14, ~d, 1'b0, '0); // read address
		chk(64'(rd_data_o[35:0]), 64'(d[35:0])); // stored word
		tile.hold_reset(3);
		chk(rd_data_o[63:0], '0); // output cleared
		tile.access(1'b1, 12'h540, 8'h14, d, 1'b0, '0);
		chk(64'(rd_data_o[35:0]), '0); // memory cleared
		// Mode 0 block-memory controls, clear enabled
		wr(REG_CTRL, 32'h2050); // mode 0
		rng = nxt(rng);
		d = PORT_W'({5{rng}});
		tile.access(1'b0, '0, '0, d, 1'b1, 6'h09);
		tile.access(1'b1, '0, '0, ~d, 1'b1, 6'h09);
		chk(64'(rd_data_o[35:0]), 64'(d[35:0])); // block-memory path
		tile.hold_reset(3);
		chk(64'(rd_data_o[35:0]), 64'(d[35:0])); // reset ignored
		// Shared clock, falling edges, 144-bit words, sync output reset
		wr(REG_CTRL, 32'hcca5); // sync fall
		rng = nxt(rng);
		d = PORT_W'({5{rng}});
		tile.access(1'b0, 12'h080, 8'h08, d, 1'b0, '0); // wide write
		tile.access(1'b0, 12'h240, 8'h08, ~d, 1'b0, '0); // read on write pin
		chk(rd_data_o[143:80], d[143:80]); // wide word
		tile.hold_reset(3);
		chk(rd_data_o[63:0], d[63:0]); // sync reset waits for edge
		give_verdict();
	end
endmodule
